// ===== src/dmacc_channel.sv
// dma channel: apb registers, request gating and transfer sequencing
// assumes: one 200 mhz clock, peripheral requests asynchronous levels
//
// How it works
// - the source burst size field alone sets how many beats each request moves; the destination burst size is only stored.
// - a peripheral raises its request when ready and the channel then moves data.
// - memory to memory runs on the enable bit alone and ignores every request.
// - each accepted request moves exactly one source burst through the fifo; here a request moves only the rest of the count when fewer beats remain.
// - config bits 18..14 are ignore, fifo active, lock and two irq enables, reset 0.
// - with the ignore bit set the channel takes no peripheral request.
// - enable starts memory to memory and clears itself when the count is done.
// - the total count is in source-width elements.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`default_nettype none
`include "dmacc_defs.svh"

module dmacc_channel
  import dmacc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // peripheral requests and acknowledges
  input wire logic [15:0] dma_req_in,
  output logic [15:0] dma_ack_out,
  // datapath strobes
  output logic rd_beat_out,
  output logic wr_beat_out,
  output logic lock_out,
  output logic busy_out,
  // interrupt
  output logic irq_out
);
  typedef struct packed {
    dmacc_state_e st;
    logic [11:0] size;
    logic [2:0] sbsize;
    logic [2:0] dbsize;
    logic [2:0] swidth;
    logic [2:0] dwidth;
    logic halt;
    logic lock;
    logic done_irq_enable;
    logic error_irq_enable;
    logic [2:0] flow;
    logic [3:0] dst_periph_select;
    logic [3:0] src_periph_select;
    logic en;
    logic [3:0] cur_sel;
    logic wait_low;
    logic start;
    dmacc_beats_t beats;
    logic [1:0] sts;
    logic [1:0] msk;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irq;
    logic [15:0] ack;
    logic lock_o;
    logic busy_o;
    logic rd_o;
    logic wr_o;
  } dmacc_chan_s;

  dmacc_chan_s q;
  dmacc_chan_s d;
  logic [15:0] req_sync;
  dmacc_burst_if bif ();

  // ==========================================================
  // sub blocks
  dmacc_sync #(.W(16)) u_req_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in(dma_req_in),
    .sync_out(req_sync)
  );

  dmacc_burst u_burst (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .bif(bif)
  );

  assign bif.start = q.start;
  assign bif.beats = q.beats;

  // ==========================================================
  // helpers
  function automatic dmacc_beats_t burst_beats(input logic [2:0] code);
    dmacc_beats_t b;
    b = 9'h001;
    if (code != 3'h0) begin
      b = dmacc_beats_t'(9'h002 << code); // 4, 8, ... 256
    end
    return b;
  endfunction

  logic [31:0] cfg_rd;
  logic [31:0] ctrl_rd;
  logic acc;
  logic wr_acc;
  logic hit_ctrl;
  logic hit_cfg;
  logic hit_sts;
  logic hit_msk;
  logic [3:0] req_sel;
  logic req_seen;
  logic [1:0] ev;
  dmacc_beats_t want;

  always_comb begin
    cfg_rd = '0;
    cfg_rd[`DMACC_CFG_HALT] = q.halt;
    cfg_rd[`DMACC_CFG_ACTIVE] = bif.active;
    cfg_rd[`DMACC_CFG_LOCK] = q.lock;
    cfg_rd[`DMACC_CFG_DIE] = q.done_irq_enable;
    cfg_rd[`DMACC_CFG_EIE] = q.error_irq_enable;
    cfg_rd[`DMACC_CFG_FLOW_LSB +: 3] = q.flow;
    cfg_rd[`DMACC_CFG_DSEL_LSB +: 4] = q.dst_periph_select;
    cfg_rd[`DMACC_CFG_SSEL_LSB +: 4] = q.src_periph_select;
    cfg_rd[`DMACC_CFG_EN] = q.en;
    ctrl_rd = '0;
    ctrl_rd[`DMACC_CTRL_SIZE_LSB +: 12] = q.size;
    ctrl_rd[`DMACC_CTRL_SBS_LSB +: 3] = q.sbsize;
    ctrl_rd[`DMACC_CTRL_DBS_LSB +: 3] = q.dbsize;
    ctrl_rd[`DMACC_CTRL_SW_LSB +: 3] = q.swidth;
    ctrl_rd[`DMACC_CTRL_DW_LSB +: 3] = q.dwidth;
  end

  assign hit_ctrl = (paddr_in == `DMACC_OFF_CTRL);
  assign hit_cfg = (paddr_in == `DMACC_OFF_CFG);
  assign hit_sts = (paddr_in == `DMACC_OFF_STS);
  assign hit_msk = (paddr_in == `DMACC_OFF_MSK);
  // access phase answers on its second cycle, write lands with pready
  assign acc = psel_in && penable_in && q.ready;
  assign wr_acc = acc && pwrite_in;

  // memory destination uses the source select for the request line
  assign req_sel = (q.flow == `DMACC_FLOW_M2P) ? q.dst_periph_select : q.src_periph_select;
  assign req_seen = req_sync[req_sel];
  // never more beats than remain in the count
  assign want = (q.size < 12'(burst_beats(q.sbsize))) ?
                q.size[8:0] : burst_beats(q.sbsize);

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    ev = 2'b00;
    d.start = 1'b0;
    d.ack = '0;
    d.ready = psel_in && penable_in && !q.ready;
    d.slverr = psel_in && penable_in && !q.ready &&
               !(hit_ctrl || hit_cfg || hit_sts || hit_msk);
    d.rdata = '0;
    if (psel_in && penable_in && !q.ready && !pwrite_in) begin
      if (hit_ctrl) begin
        d.rdata = ctrl_rd;
      end else if (hit_cfg) begin
        d.rdata = cfg_rd;
      end else if (hit_sts) begin
        d.rdata = {30'h0, q.sts};
      end else if (hit_msk) begin
        d.rdata = {30'h0, q.msk};
      end
    end

    // register writes
    if (wr_acc && hit_ctrl && q.st == DMACC_IDLE) begin
      d.size = pwdata_in[`DMACC_CTRL_SIZE_LSB +: 12];
      d.sbsize = pwdata_in[`DMACC_CTRL_SBS_LSB +: 3];
      d.dbsize = pwdata_in[`DMACC_CTRL_DBS_LSB +: 3];
      d.swidth = pwdata_in[`DMACC_CTRL_SW_LSB +: 3];
      d.dwidth = pwdata_in[`DMACC_CTRL_DW_LSB +: 3];
    end
    if (wr_acc && hit_cfg) begin
      d.halt = pwdata_in[`DMACC_CFG_HALT];
      d.lock = pwdata_in[`DMACC_CFG_LOCK];
      d.done_irq_enable = pwdata_in[`DMACC_CFG_DIE];
      d.error_irq_enable = pwdata_in[`DMACC_CFG_EIE];
      d.flow = pwdata_in[`DMACC_CFG_FLOW_LSB +: 3];
      d.dst_periph_select = pwdata_in[`DMACC_CFG_DSEL_LSB +: 4];
      d.src_periph_select = pwdata_in[`DMACC_CFG_SSEL_LSB +: 4];
      d.en = pwdata_in[`DMACC_CFG_EN];
    end
    if (wr_acc && hit_msk) begin
      d.msk = pwdata_in[1:0];
    end

    // a peripheral must drop its request before it can be taken again
    if (q.wait_low && !req_seen) begin
      d.wait_low = 1'b0;
    end

    // sequencer
    case (q.st)
      DMACC_IDLE: begin
        if (q.en) begin
          if (q.flow > `DMACC_FLOW_P2P) begin
            ev[`DMACC_STS_ERR] = 1'b1;
            d.en = 1'b0;
          end else if (q.size == 12'h000) begin
            ev[`DMACC_STS_DONE] = 1'b1;
            d.en = 1'b0;
          end else if (q.flow == `DMACC_FLOW_M2M) begin
            d.start = 1'b1;
            d.beats = want;
            d.size = q.size - 12'(want);
            d.st = DMACC_BURST;
          end else begin
            d.st = DMACC_WAIT;
          end
        end
      end
      DMACC_WAIT: begin
        if (!q.en) begin
          d.st = DMACC_IDLE;
        end else if (req_seen && !q.halt && !q.wait_low) begin
          d.cur_sel = req_sel;
          d.start = 1'b1;
          d.beats = want;
          d.size = q.size - 12'(want);
          d.st = DMACC_BURST;
        end
      end
      DMACC_BURST: begin
        if (bif.done) begin
          if (q.flow != `DMACC_FLOW_M2M) begin
            d.ack[q.cur_sel] = 1'b1;
            d.wait_low = 1'b1;
          end
          if (q.size == 12'h000) begin
            ev[`DMACC_STS_DONE] = 1'b1;
            d.en = 1'b0;
            d.st = DMACC_IDLE;
          end else if (!q.en) begin
            d.st = DMACC_IDLE;
          end else if (q.flow == `DMACC_FLOW_M2M) begin
            d.start = 1'b1;
            d.beats = want;
            d.size = q.size - 12'(want);
          end else begin
            d.st = DMACC_WAIT;
          end
        end
      end
      default: begin
        d.st = DMACC_IDLE;
      end
    endcase

    // interrupt status: enables gate the events, set beats write-one clear
    if (wr_acc && hit_sts) begin
      d.sts = q.sts & ~pwdata_in[1:0];
    end
    d.sts = d.sts | (ev & {q.error_irq_enable, q.done_irq_enable});
    d.irq = |(d.sts & d.msk);

    d.busy_o = (d.st != DMACC_IDLE);
    d.lock_o = q.lock && (bif.busy || d.start);
    d.rd_o = 1'b0;
    d.wr_o = 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.st <= DMACC_IDLE;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign prdata_out = q.rdata;
  assign pready_out = q.ready;
  assign pslverr_out = q.slverr;
  assign dma_ack_out = q.ack;
  assign rd_beat_out = bif.rd_beat;
  assign wr_beat_out = bif.wr_beat;
  assign lock_out = q.lock_o;
  assign busy_out = q.busy_o;
  assign irq_out = q.irq;
endmodule // dmacc_channel

`default_nettype wire

// ===== src/dmacc_defs.svh
// register offsets, field positions, reset values and codes of the dma channel
// assumes: included by bare name from the channel source
`ifndef DMACC_DEFS_SVH
`define DMACC_DEFS_SVH

// ==========================================================
// apb byte offsets
`define DMACC_OFF_CTRL 12'h000
`define DMACC_OFF_CFG 12'h004
`define DMACC_OFF_STS 12'h008
`define DMACC_OFF_MSK 12'h00c

// ==========================================================
// control register fields
`define DMACC_CTRL_SIZE_LSB 0
`define DMACC_CTRL_SBS_LSB 12
`define DMACC_CTRL_DBS_LSB 15
`define DMACC_CTRL_SW_LSB 18
`define DMACC_CTRL_DW_LSB 21
`define DMACC_CTRL_RST 32'h0000_0000

// ==========================================================
// configuration register fields
`define DMACC_CFG_HALT 18
`define DMACC_CFG_ACTIVE 17
`define DMACC_CFG_LOCK 16
`define DMACC_CFG_DIE 15
`define DMACC_CFG_EIE 14
`define DMACC_CFG_FLOW_LSB 11
`define DMACC_CFG_DSEL_LSB 6
`define DMACC_CFG_SSEL_LSB 1
`define DMACC_CFG_EN 0
`define DMACC_CFG_RST 32'h0000_0000

// ==========================================================
// interrupt status bits and transfer methods
`define DMACC_STS_DONE 0
`define DMACC_STS_ERR 1
`define DMACC_FLOW_M2M 3'h0
`define DMACC_FLOW_M2P 3'h1
`define DMACC_FLOW_P2M 3'h2
`define DMACC_FLOW_P2P 3'h3

`endif

// ===== src/dmacc_pkg.sv
// types shared by the dma channel modules
// assumes: compiled before any module of the channel
`default_nettype none

package dmacc_pkg;
  typedef logic [8:0] dmacc_beats_t;
  typedef enum logic [1:0] {
    DMACC_IDLE,
    DMACC_WAIT,
    DMACC_BURST
  } dmacc_state_e;
endpackage

`default_nettype wire

// ===== src/dmacc_burst_if.sv
// burst handshake between the channel sequencer and the beat engine
// assumes: start is a one-cycle pulse given only while busy is low
`default_nettype none

interface dmacc_burst_if;
  import dmacc_pkg::*;
  logic start;
  dmacc_beats_t beats;
  logic busy;
  logic done;
  logic rd_beat;
  logic wr_beat;
  logic active;
  modport ctl (output start, output beats, input busy, input done, input rd_beat,
    input wr_beat, input active);
  modport eng (input start, input beats, output busy, output done, output rd_beat,
    output wr_beat, output active);
endinterface

`default_nettype wire

// ===== src/dmacc_sync.sv
// two-flop synchroniser for a bus of asynchronous levels
// assumes: each bit is an independent level, no bus coherency needed
`default_nettype none

module dmacc_sync #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dmacc_sync_s;

  dmacc_sync_s q;
  dmacc_sync_s d;

  always_comb begin
    d.s1 = async_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.s2;
endmodule // dmacc_sync

`default_nettype wire

// ===== src/dmacc_burst.sv
// beat engine: reads a burst into the channel fifo, then drains it
// assumes: start pulses only while busy is low; beats is at least one
`default_nettype none

module dmacc_burst
  import dmacc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // sequencer side
  dmacc_burst_if.eng bif
);
  typedef struct packed {
    dmacc_beats_t n;
    dmacc_beats_t cnt;
    dmacc_beats_t level;
    logic rd_ph;
    logic wr_ph;
    logic rd;
    logic wr;
    logic done;
  } dmacc_burst_s;

  dmacc_burst_s q;
  dmacc_burst_s d;

  // ==========================================================
  // beat sequencing
  always_comb begin
    d = q;
    d.rd = 1'b0;
    d.wr = 1'b0;
    d.done = 1'b0;
    if (bif.start && !q.rd_ph && !q.wr_ph) begin
      d.n = bif.beats;
      d.cnt = bif.beats;
      d.rd_ph = 1'b1;
    end else if (q.rd_ph) begin
      // source beats fill the fifo first
      d.rd = 1'b1;
      d.level = q.level + 9'h001;
      d.cnt = q.cnt - 9'h001;
      if (q.cnt == 9'h001) begin
        d.rd_ph = 1'b0;
        d.wr_ph = 1'b1;
        d.cnt = q.n;
      end
    end else if (q.wr_ph) begin
      d.wr = 1'b1;
      d.level = q.level - 9'h001;
      d.cnt = q.cnt - 9'h001;
      if (q.cnt == 9'h001) begin
        d.wr_ph = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bif.busy = q.rd_ph | q.wr_ph;
  assign bif.done = q.done;
  assign bif.rd_beat = q.rd;
  assign bif.wr_beat = q.wr;
  assign bif.active = (q.level != 9'h000);
endmodule // dmacc_burst

`default_nettype wire

// ===== sim/dmacc_periph_model.sv
// peripheral model: raises one request level, drops it when acknowledged
// assumes: bench asks for one request at a time
`default_nettype none
module dmacc_periph_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // bench control
  input wire logic go_in,
  input wire logic drop_in,
  input wire logic [3:0] line_in,
  input wire logic [3:0] delay_in,
  // request link
  input wire logic [15:0] ack_in,
  output logic [15:0] req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic [3:0] sel_q;
  logic pend_q;
  // =====================================================
  // request level
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || drop_in) begin
      cnt_q <= 4'h0;
      sel_q <= 4'h0;
      pend_q <= 1'b0;
      req_out <= 16'h0000;
    end else if (go_in) begin
      pend_q <= 1'b1;
      sel_q <= line_in;
      cnt_q <= delay_in;
    end else if (pend_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (pend_q) begin
      req_out <= 16'h0001 << sel_q;
      pend_q <= 1'b0;
    end else begin
      // held until serviced, so a slow channel never loses it
      req_out <= req_out & ~ack_in;
    end
  end
endmodule // dmacc_periph_model
`default_nettype wire

// ===== sim/dmacc_channel_props.sv
// checker of the channel's port relations
// assumes: bound to dmacc_channel, one clock domain
`default_nettype none
module dmacc_channel_props (
  // clock, reset, apb
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // requests and strobes
  input wire logic [15:0] dma_req_in,
  input wire logic [15:0] dma_ack_out,
  input wire logic rd_beat_out,
  input wire logic wr_beat_out,
  input wire logic lock_out,
  input wire logic busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // =====================================================
  // beats sitting in the fifo
  logic [8:0] bal_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bal_q <= 9'h000;
    end else begin
      bal_q <= bal_q + {8'h00, rd_beat_out} - {8'h00, wr_beat_out};
    end
  end
  // =====================================================
  // properties
  property p_rdy;
    pready_out |-> psel_in && penable_in && $past(penable_in);
  endproperty
  property p_err;
    pslverr_out |-> pready_out && (paddr_in[11:4] != 8'h00 || paddr_in[1:0] != 2'h0);
  endproperty
  property p_rdz;
    !pready_out |-> prdata_out == 32'h0;
  endproperty
  property p_ack;
    |dma_ack_out |-> $onehot(dma_ack_out) && (dma_ack_out & $past(dma_req_in, 3)) != 16'h0;
  endproperty
  property p_bal;
    |dma_ack_out |-> bal_q == 9'h000;
  endproperty
  property p_wr;
    wr_beat_out |-> bal_q != 9'h000;
  endproperty
  property p_mix;
    rd_beat_out |-> !wr_beat_out && busy_out;
  endproperty
  property p_lock;
    lock_out |-> busy_out;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready outside access");
  a_err: assert property (p_err) else $error("error on mapped word");
  a_rdz: assert property (p_rdz) else $error("read data outside access");
  a_ack: assert property (p_ack) else $error("ack without request");
  a_bal: assert property (p_bal) else $error("ack with fifo not drained");
  a_wr: assert property (p_wr) else $error("write beat from empty fifo");
  a_mix: assert property (p_mix) else $error("read beat out of place");
  a_lock: assert property (p_lock) else $error("lock while idle");
  c_ack: cover property (|dma_ack_out);
  c_err: cover property (pslverr_out);
  c_lock: cover property (lock_out);
endmodule // dmacc_channel_props
bind dmacc_channel dmacc_channel_props i_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .dma_req_in(dma_req_in),
  .dma_ack_out(dma_ack_out), .rd_beat_out(rd_beat_out), .wr_beat_out(wr_beat_out),
  .lock_out(lock_out), .busy_out(busy_out));
`default_nettype wire

// ===== sim/dmacc_channel_test.sv
// bench of the dma channel: apb master, peripheral model, scenarios
// assumes: design, checker and model compiled before
`default_nettype none
module dmacc_channel_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, drop = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, rerr, rd_beat, wr_beat, lock, busy, irq;
  logic [3:0] line = 4'h0, dly = 4'h0;
  logic [15:0] req, ack;
  int errors = 0;
  int samples_checked = 0;
  always #2.5 clk_in = ~clk_in;
  dmacc_channel i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .dma_req_in(req),
    .dma_ack_out(ack), .rd_beat_out(rd_beat), .wr_beat_out(wr_beat), .lock_out(lock),
    .busy_out(busy), .irq_out(irq));
  dmacc_periph_model i_periph (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go),
    .drop_in(drop), .line_in(line), .delay_in(dly), .ack_in(ack), .req_out(req));
  // =====================================================
  // shared tasks
  task automatic give_verdict();
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr = pslverr;
    if (n >= 20) begin
      chk(32'h1, 32'h0);
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask
  // counts beats from a request until its acknowledge or the bound
  task automatic burst(input logic [3:0] ln, input int nb, input logic [15:0] ak, input int lim,
    input logic lk_exp);
    int n, r, wb;
    logic lk;
    n = 0;
    r = 0;
    wb = 0;
    lk = 1'b0;
    line <= ln;
    go <= 1'b1;
    do begin
      @(posedge clk_in);
      go <= 1'b0;
      n++;
      r += rd_beat;
      wb += wr_beat;
      lk |= lock;
    end while (ack === 16'h0 && n < lim);
    chk(r, nb);
    chk(wb, nb);
    chk(ack, ak);
    chk(lk, lk_exp);
    if (ak !== 16'h0 && n >= lim) begin
      give_verdict();
    end
  endtask
  // =====================================================
  // scenarios
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rdata, 32'h0);
    end
    apb(1'b1, 12'h010, 32'hffff_ffff);
    chk(rerr, 1'b1);
    apb(1'b1, 12'h004, 32'h0007_dbde);
    apb(1'b0, 12'h004, 32'h0);
    chk(rdata, 32'h0005_dbde);
    apb(1'b1, 12'h004, 32'h0);
  endtask
  task automatic t_p2m();
    apb(1'b1, 12'h00c, 32'h1);
    // equal byte widths keep any count whole
    apb(1'b1, 12'h000, 32'h0000_1006);
    apb(1'b1, 12'h004, 32'h0001_900b);
    burst(4'h5, 4, 16'h0020, 600, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rdata, 32'h0000_1002);
    dly <= 4'h9;
    burst(4'h5, 2, 16'h0020, 600, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rdata, 32'h0001_900a);
    chk(irq, 1'b1);
    apb(1'b1, 12'h00c, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, 12'h00c, 32'h1);
    chk(irq, 1'b1);
    apb(1'b1, 12'h008, 32'h1);
    chk(irq, 1'b0);
    dly <= 4'h0;
  endtask
  task automatic t_halt();
    apb(1'b1, 12'h000, 32'h0000_0002);
    apb(1'b1, 12'h004, 32'h0004_0881);
    burst(4'h2, 0, 16'h0, 40, 1'b0);
    drop <= 1'b1;
    @(posedge clk_in);
    drop <= 1'b0;
    apb(1'b1, 12'h004, 32'h0000_0881);
    burst(4'h2, 1, 16'h0004, 200, 1'b0);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rdata, 32'h0);
    chk(busy, 1'b0);
  endtask
  task automatic t_m2m();
    apb(1'b1, 12'h000, 32'h0000_1005);
    apb(1'b1, 12'h004, 32'h0000_8007);
    burst(4'h3, 5, 16'h0, 150, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rdata, 32'h0000_8006);
    apb(1'b0, 12'h008, 32'h0);
    chk(rdata, 32'h1);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h004, 32'h0000_6001);
    apb(1'b0, 12'h008, 32'h0);
    chk(rdata, 32'h2);
  endtask
  // =====================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_regs();
    t_p2m();
    t_halt();
    t_m2m();
    give_verdict();
  end
endmodule // dmacc_channel_test
`default_nettype wire
